//--- src/lcr_map.svh
`ifndef LCR_MAP_SVH
`define LCR_MAP_SVH
// Register byte addresses
`define LCR_ADDR_STATUS 8'h01
`define LCR_ADDR_CH2_CFG 8'h15
`define LCR_ADDR_CH2_OCT 8'h16
`define LCR_ADDR_CH2_RMON 8'h17
`define LCR_ADDR_CH2_REF_HI 8'h18
`define LCR_ADDR_CH2_REF_LO 8'h19
`define LCR_ADDR_CH2_AUX 8'h1a
`define LCR_ADDR_GEN 8'h1b
`define LCR_ADDR_MODE 8'h1c
`define LCR_ADDR_MASK 8'h1d
// Field positions
`define LCR_BIT_REG_SEL 0
`define LCR_BIT_CAP 1
`define LCR_BIT_RDIS 2
`define LCR_BIT_PINBLK 3
`define LCR_BIT_OFFC 4
`define LCR_BIT_RANGE 4
`define LCR_BIT_FSENSE 6
`define LCR_BIT_EXTDRV 7
`define LCR_BIT_COMBINE 6
`define LCR_BIT_MOSC 0
`define LCR_BIT_MMON 1
`define LCR_BIT_MSAT1 2
`define LCR_BIT_SAT2 6
// Reset values
`define LCR_RST_CH2_CFG 8'h18
`define LCR_RST_OCT 8'hff
`define LCR_RST_RMON 8'hff
`define LCR_RST_COMP 3'h3
`define LCR_RST_SATTH 2'h0
`define LCR_RST_REF 10'h000
`define LCR_RST_AUX 8'h00
`define LCR_RST_CCUR 6'h02
`define LCR_RST_MODE 2'h1
`define LCR_RST_MASK 3'h6
// Mode codes
`define LCR_MODE_OPER 2'h1
`define LCR_MODE_CONF 2'h2
`endif

//--- src/lcr_pkg.sv
`default_nettype none
package lcr_pkg;
  // Register storage and live copies
  typedef struct packed {
    logic [7:0] ch2_cfg;
    logic [7:0] ch2_overcurrent_threshold;
    logic [7:0] ch2_monitor_resistor_code;
    logic [2:0] ch2_compensation_current;
    logic [1:0] ch2_saturation_threshold;
    logic [9:0] ch2_reference_code;
    logic [7:0] ch2_aux;
    logic [5:0] converter_control_current;
    logic channel_combine;
    logic [1:0] operating_state_select;
    logic [2:0] masks;
    logic ch1_sat_pend;
    logic ch2_sat_pend;
    logic [7:0] rdata;
    logic [7:0] live_cfg;
    logic [7:0] live_aux;
    logic [7:0] live_oct;
    logic [7:0] live_rmon;
    logic [2:0] live_comp;
    logic [1:0] live_satth;
    logic [9:0] live_ref;
    logic [5:0] live_ccur;
    logic live_combine;
  } lcr_state_t;
endpackage
`default_nettype wire

//--- src/lcr_regs.sv
// Overview of operation
// - Regulation select: 0 light power, 1 current
// - Loop capacitor connect bit, reset 0
// - Monitor resistor disable bit, reset 0
// - Pin enable block, reset 1
// - Offset compensation enable, reset 1
// - ADC source field, 0xx disables, reset 000
// - Force/sense picks monitor node for 100
// - Overcurrent threshold reset FF, zero disables under current regulation
// - Monitor resistor code resets to FF
// - Compensation current field resets to 011
// - Saturation threshold field resets to 00
// - Ten-bit reference over two bytes, reset 0
// - Current range: 0 high, 1 low
// - External driver enable, reset 0
// - Converter control current, reset 0x02
// - Channel combine parallels channel 2, reset 0
// - Mode 01 applies, 10 holds settings
// - Oscillator error mask, reset 0
// - Pin monitor mask, reset 1
// - Channel 1 saturation mask, reset 1
// - Saturation status sticky, cleared on read
`timescale 1ns/1ps
`default_nettype none
`include "lcr_map.svh"
module lcr_regs
  import lcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic ch1_saturation_i,
  input wire logic ch2_saturation_i,
  input wire logic osc_error_i,
  input wire logic ch1_pin_monitor_event_i,
  input wire logic ch2_pin_monitor_event_i,
  input wire logic ch2_enable_pin_i,
  output logic ch2_regulation_select_o,
  output logic ch2_loop_cap_connect_o,
  output logic ch2_resistor_disable_o,
  output logic ch2_offset_comp_enable_o,
  output logic ch2_pin_enabled_o,
  output logic [2:0] ch2_adc_source_o,
  output logic ch2_adc_enable_o,
  output logic ch2_adc_force_sense_o,
  output logic [7:0] ch2_overcurrent_threshold_o,
  output logic ch2_overcurrent_enable_o,
  output logic [7:0] ch2_monitor_resistor_code_o,
  output logic [2:0] ch2_compensation_current_o,
  output logic [1:0] ch2_saturation_threshold_o,
  output logic [9:0] ch2_reference_code_o,
  output logic ch2_current_range_o,
  output logic ch2_external_driver_enable_o,
  output logic [5:0] converter_control_current_o,
  output logic channel_combine_o,
  output logic config_hold_o,
  output logic fault_output_n_o
);

  // Everything clocked lives in one packed struct. Stored registers take
  // writes at once; the live copy is what the analog side sees, and it
  // follows the stored values only while the mode field says operation.
  // In hold mode software may edit both reference bytes and then release
  // them together, so the loop never sees a half-written code.
  lcr_state_t st; // Registered state
  lcr_state_t next_st; // Next state
  logic oper; // Operation mode: latch transparent
  logic fault_raw; // Any unmasked pending event

  assign oper = (st.operating_state_select == `LCR_MODE_OPER);

  // Only input levels and the sticky channel 1 flag feed the pin, so it
  // falls in the cycle an unmasked level event appears and rises once the
  // event is gone. Channel 2 saturation only reaches the status byte here.
  // Unmasked event gathering for the fault pin
  always_comb begin
    fault_raw = (osc_error_i & ~st.masks[`LCR_BIT_MOSC])
              | ((ch1_pin_monitor_event_i | ch2_pin_monitor_event_i) & ~st.masks[`LCR_BIT_MMON])
              | (st.ch1_sat_pend & ~st.masks[`LCR_BIT_MSAT1]);
  end

  // Write and read decode share one address; a read in the same cycle as
  // a write returns the old contents. Unmapped addresses read as zero and
  // ignore writes. Later assignments in this process win, which is how a
  // new saturation event beats the clear of a status read.
  // Next-state logic: writes, reads, sticky flags, latch
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    // Register writes
    if (wr_i) begin
      unique case (addr_i)
        `LCR_ADDR_CH2_CFG: next_st.ch2_cfg = wdata_i;
        `LCR_ADDR_CH2_OCT: next_st.ch2_overcurrent_threshold = wdata_i;
        `LCR_ADDR_CH2_RMON: next_st.ch2_monitor_resistor_code = wdata_i;
        `LCR_ADDR_CH2_REF_HI: begin
          next_st.ch2_compensation_current = wdata_i[6:4];
          next_st.ch2_saturation_threshold = wdata_i[3:2];
          next_st.ch2_reference_code[9:8] = wdata_i[1:0];
        end
        `LCR_ADDR_CH2_REF_LO: next_st.ch2_reference_code[7:0] = wdata_i;
        `LCR_ADDR_CH2_AUX: begin
          next_st.ch2_aux[`LCR_BIT_RANGE] = wdata_i[`LCR_BIT_RANGE];
          next_st.ch2_aux[`LCR_BIT_FSENSE] = wdata_i[`LCR_BIT_FSENSE];
          next_st.ch2_aux[`LCR_BIT_EXTDRV] = wdata_i[`LCR_BIT_EXTDRV];
        end
        `LCR_ADDR_GEN: begin
          next_st.converter_control_current = wdata_i[5:0];
          next_st.channel_combine = wdata_i[`LCR_BIT_COMBINE];
        end
        `LCR_ADDR_MODE: begin
          // Illegal codes ignored, keeps latch state defined
          if (wdata_i[1:0] == `LCR_MODE_OPER || wdata_i[1:0] == `LCR_MODE_CONF) begin
            next_st.operating_state_select = wdata_i[1:0];
          end
        end
        `LCR_ADDR_MASK: next_st.masks = wdata_i[2:0];
        default: ;
      endcase
    end
    // Register reads
    if (rd_i) begin
      unique case (addr_i)
        `LCR_ADDR_STATUS: begin
          next_st.rdata[`LCR_BIT_SAT2] = st.ch2_sat_pend;
          next_st.ch2_sat_pend = 1'b0;
        end
        `LCR_ADDR_CH2_CFG: next_st.rdata = st.ch2_cfg;
        `LCR_ADDR_CH2_OCT: next_st.rdata = st.ch2_overcurrent_threshold;
        `LCR_ADDR_CH2_RMON: next_st.rdata = st.ch2_monitor_resistor_code;
        `LCR_ADDR_CH2_REF_HI: next_st.rdata = {1'b0, st.ch2_compensation_current,
                                               st.ch2_saturation_threshold, st.ch2_reference_code[9:8]};
        `LCR_ADDR_CH2_REF_LO: next_st.rdata = st.ch2_reference_code[7:0];
        `LCR_ADDR_CH2_AUX: next_st.rdata = st.ch2_aux;
        `LCR_ADDR_GEN: next_st.rdata = {1'b0, st.channel_combine, st.converter_control_current};
        `LCR_ADDR_MODE: next_st.rdata = {6'h00, st.operating_state_select};
        `LCR_ADDR_MASK: next_st.rdata = {5'h00, st.masks};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // Sticky saturation flags, set wins over read clear
    if (ch2_saturation_i) begin
      next_st.ch2_sat_pend = 1'b1;
    end
    if (ch1_saturation_i) begin
      next_st.ch1_sat_pend = 1'b1;
    end
    // Channel 1 flag clears when masked and not asserted
    if (st.masks[`LCR_BIT_MSAT1] && !ch1_saturation_i) begin
      next_st.ch1_sat_pend = 1'b0;
    end
    // Configuration latch follows registers in operation mode
    // In hold mode the live copy keeps its last value
    if (oper) begin
      next_st.live_cfg = st.ch2_cfg;
      next_st.live_aux = st.ch2_aux;
      next_st.live_oct = st.ch2_overcurrent_threshold;
      next_st.live_rmon = st.ch2_monitor_resistor_code;
      next_st.live_comp = st.ch2_compensation_current;
      next_st.live_satth = st.ch2_saturation_threshold;
      next_st.live_ref = st.ch2_reference_code;
      next_st.live_ccur = st.converter_control_current;
      next_st.live_combine = st.channel_combine;
    end
  end

  // Reset loads the stored and the live copy alike, so the outputs show
  // the default configuration from the first cycle after release.
  // State register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st.ch2_cfg <= `LCR_RST_CH2_CFG;
      st.ch2_overcurrent_threshold <= `LCR_RST_OCT;
      st.ch2_monitor_resistor_code <= `LCR_RST_RMON;
      st.ch2_compensation_current <= `LCR_RST_COMP;
      st.ch2_saturation_threshold <= `LCR_RST_SATTH;
      st.ch2_reference_code <= `LCR_RST_REF;
      st.ch2_aux <= `LCR_RST_AUX;
      st.converter_control_current <= `LCR_RST_CCUR;
      st.channel_combine <= 1'b0;
      st.operating_state_select <= `LCR_RST_MODE;
      st.masks <= `LCR_RST_MASK;
      st.ch1_sat_pend <= 1'b0;
      st.ch2_sat_pend <= 1'b0;
      st.rdata <= 8'h00;
      st.live_cfg <= `LCR_RST_CH2_CFG;
      st.live_aux <= `LCR_RST_AUX;
      st.live_oct <= `LCR_RST_OCT;
      st.live_rmon <= `LCR_RST_RMON;
      st.live_comp <= `LCR_RST_COMP;
      st.live_satth <= `LCR_RST_SATTH;
      st.live_ref <= `LCR_RST_REF;
      st.live_ccur <= `LCR_RST_CCUR;
      st.live_combine <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Every configuration output comes from the live copy, never from the
  // stored registers, so hold mode freezes the whole set at once.
  // The pin gate stays combinational so the enable pin acts at once.
  // Outputs from the applied configuration
  assign rdata_o = st.rdata;
  assign ch2_regulation_select_o = st.live_cfg[`LCR_BIT_REG_SEL];
  assign ch2_loop_cap_connect_o = st.live_cfg[`LCR_BIT_CAP];
  assign ch2_resistor_disable_o = st.live_cfg[`LCR_BIT_RDIS];
  assign ch2_pin_enabled_o = ch2_enable_pin_i & ~st.live_cfg[`LCR_BIT_PINBLK];
  assign ch2_offset_comp_enable_o = st.live_cfg[`LCR_BIT_OFFC];
  // Converter selection, off while the top source bit is clear
  assign ch2_adc_source_o = st.live_cfg[7:5];
  assign ch2_adc_enable_o = st.live_cfg[7];
  assign ch2_adc_force_sense_o = st.live_aux[`LCR_BIT_FSENSE];
  // Overcurrent detection and the analog set points
  assign ch2_overcurrent_threshold_o = st.live_oct;
  assign ch2_overcurrent_enable_o = ~((st.live_oct == 8'h00) & st.live_cfg[`LCR_BIT_REG_SEL]);
  assign ch2_monitor_resistor_code_o = st.live_rmon;
  assign ch2_compensation_current_o = st.live_comp;
  assign ch2_saturation_threshold_o = st.live_satth;
  assign ch2_reference_code_o = st.live_ref;
  assign ch2_current_range_o = st.live_aux[`LCR_BIT_RANGE];
  assign ch2_external_driver_enable_o = st.live_aux[`LCR_BIT_EXTDRV];
  // General settings, mode decode and fault pin
  assign converter_control_current_o = st.live_ccur;
  assign channel_combine_o = st.live_combine;
  assign config_hold_o = ~oper;
  assign fault_output_n_o = ~fault_raw;

  // Checks and covers, all on the register clock and quiet during reset.
  // Each check carries a short name on its label line;
  // a failure prints one line and the run goes on.

  // A channel 2 saturation event always leaves the flag set
  chk_sat_sticky: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ch2_saturation_i |=> st.ch2_sat_pend
  ) else $error("saturation flag not set");

  // A status read clears the flag unless a new event arrives
  chk_sat_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == `LCR_ADDR_STATUS && !ch2_saturation_i) |=> !st.ch2_sat_pend
  ) else $error("saturation flag not cleared");

  // The status read returns the flag as it stood before the clear
  chk_sat_read_data: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == `LCR_ADDR_STATUS) |=> (rdata_o[`LCR_BIT_SAT2] == $past(st.ch2_sat_pend))
  ) else $error("status read data wrong");

  // Read data falls back to zero when no read was strobed
  chk_rdata_idle: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !rd_i |=> (rdata_o == 8'h00)
  ) else $error("read data not idle");

  // Two cycles of hold mode leave the applied reference code frozen
  chk_hold_live: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (!oper && !$past(oper)) |-> $stable(ch2_reference_code_o)
  ) else $error("held config changed");

  // Operation mode copies the stored monitor resistor code through
  chk_oper_apply: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    oper |=> (ch2_monitor_resistor_code_o == $past(st.ch2_monitor_resistor_code))
  ) else $error("config not applied");

  // Only the two legal mode codes are ever held
  chk_mode_legal: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (st.operating_state_select == `LCR_MODE_OPER) || (st.operating_state_select == `LCR_MODE_CONF)
  ) else $error("illegal mode stored");

  // A write of a forbidden mode code leaves the mode alone
  chk_mode_refuse: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `LCR_ADDR_MODE && wdata_i[1:0] != `LCR_MODE_OPER && wdata_i[1:0] != `LCR_MODE_CONF)
    |=> $stable(st.operating_state_select)
  ) else $error("forbidden mode taken");

  // Mask writes keep exactly the three mask bits
  chk_mask_store: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `LCR_ADDR_MASK) |=> (st.masks == $past(wdata_i[2:0]))
  ) else $error("mask write lost");

  // Unmasked oscillator error pulls the fault pin low
  chk_osc_fault: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (osc_error_i && !st.masks[`LCR_BIT_MOSC]) |-> !fault_output_n_o
  ) else $error("osc fault missing");

  // Unmasked channel 1 pin monitor event pulls it low
  chk_mon_mask: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ch1_pin_monitor_event_i && !st.masks[`LCR_BIT_MMON]) |-> !fault_output_n_o
  ) else $error("monitor fault missing");

  // Unmasked channel 2 pin monitor event pulls it low too
  chk_mon2_mask: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ch2_pin_monitor_event_i && !st.masks[`LCR_BIT_MMON]) |-> !fault_output_n_o
  ) else $error("monitor 2 fault missing");

  // Channel 1 saturation shows while its mask stays clear
  chk_sat1_fault: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ch1_saturation_i && !st.masks[`LCR_BIT_MSAT1]) ##1 !st.masks[`LCR_BIT_MSAT1] |-> !fault_output_n_o
  ) else $error("sat1 fault missing");

  // With nothing pending the fault pin is released
  chk_fault_rel: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (!osc_error_i && !ch1_pin_monitor_event_i && !ch2_pin_monitor_event_i && !st.ch1_sat_pend)
    |-> fault_output_n_o
  ) else $error("fault stuck");

  // Zero threshold under current regulation turns detection off
  chk_oc_disable: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ch2_overcurrent_threshold_o == 8'h00 && ch2_regulation_select_o) |-> !ch2_overcurrent_enable_o
  ) else $error("overcurrent not disabled");

  // Any other threshold keeps detection on
  chk_oc_enable: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ch2_overcurrent_threshold_o != 8'h00) |-> ch2_overcurrent_enable_o
  ) else $error("overcurrent wrongly disabled");

  // A set block bit overrides the enable pin
  chk_pin_block: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    st.live_cfg[`LCR_BIT_PINBLK] |-> !ch2_pin_enabled_o
  ) else $error("pin not blocked");

  // A clear block bit lets the pin switch the channel on
  chk_pin_pass: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ch2_enable_pin_i && !st.live_cfg[`LCR_BIT_PINBLK]) |-> ch2_pin_enabled_o
  ) else $error("pin not passed");

  // Covers for the main scenarios of the bench
  // Round trip through hold mode and back
  cov_conf_mode: cover property (
    @(posedge clk_i) disable iff (!rst_n_i)
    oper ##1 !oper ##[1:20] oper
  );

  // Status read while the saturation flag is set
  cov_sat_read: cover property (
    @(posedge clk_i) disable iff (!rst_n_i)
    st.ch2_sat_pend ##1 (rd_i && addr_i == `LCR_ADDR_STATUS)
  );

  // Fault pin going active
  cov_fault: cover property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(fault_output_n_o)
  );

  // Overcurrent detection switched off
  cov_oc_off: cover property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ch2_overcurrent_threshold_o == 8'h00) && ch2_regulation_select_o
  );

  // Forbidden mode code offered on the bus
  cov_mode_refused: cover property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == `LCR_ADDR_MODE && wdata_i[1:0] == 2'h3
  );

endmodule // lcr_regs
`default_nettype wire

//--- tb/lcr_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Register master in the place of the microcontroller
module lcr_mcu_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // Idle bus at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // One-cycle write; released lines scrambled so stale data is not seen
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // One-cycle read; data settles one cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask
endmodule // lcr_mcu_model
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Stimulus and observed outputs
  logic clk, rst_n, wr, rd, s1, s2, osc, mon1, mon2, pin, fn, adce, fs, ocen, hold;
  logic reg_sel, cap, rdis, offc, pinen, rng, ext, comb, p1;
  logic [7:0] addr, wd, rdat, oct, rmon, got, a;
  logic [2:0] src, comp;
  logic [1:0] sat;
  logic [9:0] refc;
  logic [5:0] ccur;
  // Stored and applied register images
  logic [7:0] m [8'h15:8'h1d];
  logic [7:0] lv [8'h15:8'h1d];
  logic [7:0] wmsk [8'h15:8'h1d];
  logic [71:0] rv = 72'h18ffff300000020106;
  logic [71:0] wv = 72'hffffff7fffd07f0307;
  integer mismatches, n_checks, seed, i;
  lcr_mcu_model lcr_mcu_model_inst (.clk_i(clk), .rdata_i(rdat), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd));
  lcr_regs lcr_regs_inst (
    .clk_i(clk), .rst_n_i(rst_n), .wr_i(wr), .rd_i(rd), .addr_i(addr), .wdata_i(wd), .rdata_o(rdat),
    .ch1_saturation_i(s1), .ch2_saturation_i(s2), .osc_error_i(osc), .ch1_pin_monitor_event_i(mon1),
    .ch2_pin_monitor_event_i(mon2), .ch2_enable_pin_i(pin), .ch2_regulation_select_o(reg_sel),
    .ch2_loop_cap_connect_o(cap), .ch2_resistor_disable_o(rdis), .ch2_offset_comp_enable_o(offc),
    .ch2_pin_enabled_o(pinen), .ch2_adc_source_o(src), .ch2_adc_enable_o(adce), .ch2_adc_force_sense_o(fs),
    .ch2_overcurrent_threshold_o(oct), .ch2_overcurrent_enable_o(ocen), .ch2_monitor_resistor_code_o(rmon),
    .ch2_compensation_current_o(comp), .ch2_saturation_threshold_o(sat), .ch2_reference_code_o(refc),
    .ch2_current_range_o(rng), .ch2_external_driver_enable_o(ext), .converter_control_current_o(ccur),
    .channel_combine_o(comb), .config_hold_o(hold), .fault_output_n_o(fn)
  );
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Enable pin wanders every cycle
  always @(posedge clk) pin <= 1'($random(seed));
  // Verdict and end of run
  task automatic close_out;
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Count and report one comparison
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Bus write plus model update; live image follows only in operation mode
  task automatic w(input logic [7:0] ad, input logic [7:0] d);
    lcr_mcu_model_inst.wr_reg(ad, d);
    if (ad == 8'h1c) begin
      if (d[1:0] == 2'h1 || d[1:0] == 2'h2) m[ad] = {6'h00, d[1:0]};
    end else if (ad >= 8'h15 && ad <= 8'h1d) m[ad] = d & wmsk[ad];
    if (m[8'h1c] == 8'h01) lv = m;
  endtask
  // Bus read against an expected byte
  task automatic r(input logic [7:0] ad, input logic [7:0] e);
    lcr_mcu_model_inst.rd_reg(ad, got);
    cmp(got, e);
  endtask
  // Configuration outputs against the live image
  task automatic chk_out;
    repeat (3) @(posedge clk);
    #1;
    cmp({src, adce, offc, pinen, rdis, cap, reg_sel}, {lv[8'h15][7:5], lv[8'h15][7], lv[8'h15][4], pin & ~lv[8'h15][3], lv[8'h15][2:0]});
    cmp({oct, ocen, fs, rng, ext}, {lv[8'h16], !(lv[8'h16] == 8'h00 && lv[8'h15][0]), lv[8'h1a][6], lv[8'h1a][4], lv[8'h1a][7]});
    cmp({rmon, comp, sat}, {lv[8'h17], lv[8'h18][6:4], lv[8'h18][3:2]});
    cmp({refc, ccur}, {lv[8'h18][1:0], lv[8'h19], lv[8'h1a + 8'h01][5:0]});
    cmp({comb, hold}, {lv[8'h1b][6], m[8'h1c][1:0] != 2'h1});
  endtask
  // Fault output against masks and pending events
  task automatic chk_f;
    repeat (3) @(posedge clk);
    #1;
    p1 = s1 | (p1 & ~m[8'h1d][2]);
    cmp(fn, !((osc & ~m[8'h1d][0]) | ((mon1 | mon2) & ~m[8'h1d][1]) | (p1 & ~m[8'h1d][2])));
  endtask
  // Hang guard
  initial begin
    #3000000;
    mismatches++;
    close_out;
  end
  // Main sequence
  initial begin
    seed = 10;
    mismatches = 0;
    n_checks = 0;
    {rst_n, s1, s2, osc, mon1, mon2, p1} = 7'h00;
    for (i = 0; i < 9; i++) begin
      m[8'h15 + i] = rv[71 - 8 * i -: 8];
      wmsk[8'h15 + i] = wv[71 - 8 * i -: 8];
    end
    lv = m;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, status and an unmapped place
    for (i = 0; i < 9; i++) begin
      a = 8'h15 + i[7:0];
      r(a, m[a]);
    end
    chk_out;
    r(8'h01, 8'h00);
    r(8'h20, 8'h00);
    // Random writes, unmapped ones included, each applied and the mapped ones read back
    for (i = 0; i < 40; i++) begin
      a = 8'h15 + 8'({$random(seed)} % 9);
      if (a == 8'h1c) a = 8'h30;
      w(a, 8'($random(seed)));
      if (a != 8'h30) r(a, m[a]);
      chk_out;
    end
    // Zero threshold under current regulation
    w(8'h16, 8'h00);
    w(8'h15, 8'h01);
    chk_out;
    // Hold mode freezes outputs, illegal codes refused
    w(8'h1c, 8'h02);
    w(8'h17, 8'h5a);
    w(8'h19, 8'ha5);
    chk_out;
    w(8'h1c, 8'h00);
    w(8'h1c, 8'h03);
    r(8'h1c, 8'h02);
    w(8'h1c, 8'h01);
    chk_out;
    // Sticky saturation status, cleared by read
    @(posedge clk);
    s2 <= 1'b1;
    @(posedge clk);
    s2 <= 1'b0;
    r(8'h01, 8'h40);
    r(8'h01, 8'h00);
    // Masks against random event patterns
    for (i = 0; i < 24; i++) begin
      w(8'h1d, 8'($random(seed)));
      @(posedge clk);
      {s1, osc, mon1, mon2} <= 4'($random(seed));
      chk_f;
    end
    close_out;
  end
endmodule // tb
`default_nettype wire
